// File: rtl/asc_pkg.sv
// Shared constants and types of the AES security control block.
package asc_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [9:0] CTRL_IDX = 10'h13C;
  localparam logic [9:0] STAT_IDX = 10'h13D;
  localparam logic [9:0] DATA_IDX = 10'h13E;
  localparam logic [9:0] KEY_IDX = 10'h13F;
  localparam logic [9:0] ISTAT_IDX = 10'h140;
  localparam logic [9:0] IMASK_IDX = 10'h141;
  localparam int REQ_BIT = 7;
  localparam int MODE_BIT = 5;
  localparam int DIR_BIT = 3;
  localparam int IE_BIT = 2;
  localparam int ERR_BIT = 7;
  localparam int DONE_BIT = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hAC;
  localparam logic [7:0] STAT_MASK = 8'h81;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [3:0] ROUNDS = 4'hA;
  localparam logic [3:0] LAST_PTR = 4'hF;
  localparam logic [7:0] RCON_FIRST = 8'h01;
  localparam logic [7:0] RCON_LAST = 8'h36;
  localparam logic [7:0] POLY = 8'h1B;
  localparam logic [7:0] AFFINE = 8'h63;
  localparam logic [7:0] INV_AFFINE = 8'h05;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {CS_IDLE = 1'b0, CS_RUN = 1'b1} asc_core_state_t;
endpackage

// File: rtl/asc_bytebuf.sv
// Sixteen-byte buffer filled or emptied through one byte-wide address.
`timescale 1ns/1ps
module asc_bytebuf (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] wdata,
  input wire logic load,
  input wire logic [127:0] load_val,
  output logic [7:0] rdata,
  output logic [3:0] ptr,
  output logic [127:0] blk,
  output logic complete
);
  typedef struct packed {
    logic [15:0][7:0] mem;
    logic [3:0] ptr;
    logic cmp;
  } asc_buf_st_t;
  asc_buf_st_t s_reg, s_next;

  always_comb
  begin
    s_next = s_reg;
    if (clr)
      s_next = '0;
    else if (load)
    begin
      s_next.mem = load_val;
      s_next.ptr = 4'h0;
      s_next.cmp = 1'b0;
    end
    else if (wr || rd)
    begin
      if (wr)
        s_next.mem[~s_reg.ptr] = wdata;
      s_next.ptr = s_reg.ptr + 4'h1;
      // Only the sixteenth access of a run marks the buffer usable.
      s_next.cmp = (s_reg.ptr == asc_pkg::LAST_PTR);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign rdata = s_reg.mem[~s_reg.ptr];
  assign ptr = s_reg.ptr;
  assign blk = s_reg.mem;
  assign complete = s_reg.cmp;

  chk_fill_sixteen: assert property (@(posedge clk) disable iff (!rst_n)
    ((wr || rd) && !clr && !load && ptr == asc_pkg::LAST_PTR) |=> complete)
    else $error("Sixteenth access did not complete the buffer.");
  chk_partial_run: assert property (@(posedge clk) disable iff (!rst_n)
    (complete && (wr || rd) && !clr && !load) |=> !complete)
    else $error("A new partial access run kept the buffer complete.");
endmodule

// File: rtl/asc_core.sv
// Iterative AES-128 cipher core, one round per clock in either direction.
`timescale 1ns/1ps
module asc_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  input wire logic dec,
  input wire logic [127:0] key,
  input wire logic [127:0] din,
  output logic busy,
  output logic done,
  output logic [127:0] dout,
  output logic [127:0] last_key
);
  typedef struct packed {
    asc_pkg::asc_core_state_t fsm;
    logic dec;
    logic done;
    logic [3:0] rnd;
    logic [7:0] rc;
    logic [127:0] rk;
    logic [127:0] st;
  } asc_core_st_t;
  asc_core_st_t s_reg, s_next;

  function automatic logic [7:0] rol(input logic [7:0] x, input int n);
    return (x << n) | (x >> (8 - n));
  endfunction

  function automatic logic [7:0] xt(input logic [7:0] x);
    return {x[6:0], 1'b0} ^ (x[7] ? asc_pkg::POLY : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a,
                                      input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
        p = p ^ x;
      x = xt(x);
    end
    return p;
  endfunction

  // The inverse is a^254: deep logic, but no table of 256 bytes to keep.
  function automatic logic [7:0] sbox(input logic [7:0] b, input logic inv);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h01;
    p = inv ? rol(b, 1) ^ rol(b, 3) ^ rol(b, 6) ^ asc_pkg::INV_AFFINE : b;
    for (int i = 0; i < 8; i++)
    begin
      if (i > 0)
        r = gmul(r, p);
      p = gmul(p, p);
    end
    if (!inv)
      r = r ^ rol(r, 1) ^ rol(r, 2) ^ rol(r, 3) ^ rol(r, 4) ^ asc_pkg::AFFINE;
    return r;
  endfunction

  function automatic logic [31:0] g(input logic [31:0] w,
                                   input logic [7:0] rc);
    logic [31:0] t;
    t = {w[23:0], w[31:24]};
    for (int i = 0; i < 4; i++)
      t[8*i +: 8] = sbox(t[8*i +: 8], 1'b0);
    return t ^ {rc, 24'h00_0000};
  endfunction

  // Decryption walks the schedule backwards from the final round key.
  function automatic logic [127:0] key_step(input logic [127:0] k,
                                            input logic [7:0] rc,
                                            input logic d);
    logic [31:0] w0, w1, w2, w3;
    {w0, w1, w2, w3} = k;
    if (d)
    begin
      w3 = w3 ^ w2;
      w2 = w2 ^ w1;
      w1 = w1 ^ w0;
      w0 = w0 ^ g(w3, rc);
    end
    else
    begin
      w0 = w0 ^ g(w3, rc);
      w1 = w1 ^ w0;
      w2 = w2 ^ w1;
      w3 = w3 ^ w2;
    end
    return {w0, w1, w2, w3};
  endfunction

  function automatic logic [127:0] round(input logic [127:0] st,
                                         input logic [127:0] nk,
                                         input logic d,
                                         input logic last);
    logic [15:0][7:0] a;
    logic [15:0][7:0] t;
    logic [15:0][7:0] m;
    logic [3:0][7:0] cf;
    a = st;
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
        t[15-r-4*c] = sbox(a[15-r-4*((d ? c+4-r : c+r) % 4)], d);
    if (d)
      t = t ^ nk;
    cf = d ? {8'h0E, 8'h0B, 8'h0D, 8'h09} : {8'h02, 8'h03, 8'h01, 8'h01};
    m = t;
    if (!last)
      for (int c = 0; c < 4; c++)
        for (int r = 0; r < 4; r++)
        begin
          m[15-r-4*c] = 8'h00;
          for (int k = 0; k < 4; k++)
            m[15-r-4*c] = m[15-r-4*c] ^ gmul(cf[3-k], t[15-((r+k)%4)-4*c]);
        end
    return d ? m : m ^ nk;
  endfunction

  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    case (s_reg.fsm)
      asc_pkg::CS_IDLE:
        if (start)
        begin
          s_next.fsm = asc_pkg::CS_RUN;
          s_next.dec = dec;
          s_next.rnd = 4'h1;
          s_next.rc = dec ? asc_pkg::RCON_LAST : asc_pkg::RCON_FIRST;
          s_next.rk = key;
          s_next.st = din ^ key;
        end
      asc_pkg::CS_RUN:
      begin
        s_next.rk = key_step(s_reg.rk, s_reg.rc, s_reg.dec);
        s_next.st = round(s_reg.st, s_next.rk, s_reg.dec,
                          s_reg.rnd == asc_pkg::ROUNDS);
        if (!s_reg.dec)
          s_next.rc = xt(s_reg.rc);
        else if (s_reg.rc[0])
          s_next.rc = ((s_reg.rc ^ asc_pkg::POLY) >> 1) | 8'h80;
        else
          s_next.rc = s_reg.rc >> 1;
        s_next.rnd = s_reg.rnd + 4'h1;
        if (s_reg.rnd == asc_pkg::ROUNDS)
        begin
          s_next.fsm = asc_pkg::CS_IDLE;
          s_next.done = 1'b1;
        end
      end
      default:
        s_next.fsm = asc_pkg::CS_IDLE;
    endcase
    if (abort)
    begin
      s_next.fsm = asc_pkg::CS_IDLE;
      s_next.done = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign busy = (s_reg.fsm == asc_pkg::CS_RUN);
  assign done = s_reg.done;
  assign dout = s_reg.st;
  assign last_key = s_reg.rk;

  chk_round_count: assert property (@(posedge clk)
    disable iff (!rst_n || abort) (!busy && start) |=> ##10 (done && !busy))
    else $error("Core did not finish ten rounds on time.");
endmodule

// File: rtl/asc_top.sv
// AES security control: AXI4-Lite registers, buffers, chaining and interrupt.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps

module asc_top (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic TRX_SLEEP,
  output logic IRQ
);
  typedef struct packed {
    logic aw_rdy_n;
    logic w_rdy_n;
    logic bvalid;
    logic [1:0] bresp;
    logic [11:0] awaddr;
    logic [7:0] wbyte;
    logic wen;
    logic ar_rdy_n;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [7:0] ctrl;
    logic err;
    logic done;
    logic [7:0] istat;
    logic [7:0] imask;
    logic irq;
    logic show_last;
    logic [127:0] iv;
    logic [127:0] in_blk;
    logic slp_meta;
    logic slp;
  } asc_top_st_t;
  asc_top_st_t s_reg, s_next;

  logic busy;
  logic core_done;
  logic [127:0] core_out;
  logic [15:0][7:0] core_lk;
  logic [127:0] core_din;
  logic [127:0] result;
  logic [127:0] dbuf_blk;
  logic [127:0] kbuf_blk;
  logic [7:0] dbuf_rdata;
  logic [7:0] kbuf_rdata;
  logic [3:0] kptr;
  logic dbuf_cmp;
  logic kbuf_cmp;
  logic dbuf_wr;
  logic dbuf_rd;
  logic kbuf_wr;
  logic kbuf_rd;
  logic dbuf_load;
  logic buf_clr;
  logic core_start;
  logic core_abort;
  logic ev_done;
  logic ev_err;
  logic wr_go;
  logic rd_go;
  logic wr_ok;
  logic start_req;

  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    return a[11:2] == idx;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return hit(a, asc_pkg::CTRL_IDX) || hit(a, asc_pkg::STAT_IDX) ||
           hit(a, asc_pkg::DATA_IDX) || hit(a, asc_pkg::KEY_IDX) ||
           hit(a, asc_pkg::ISTAT_IDX) || hit(a, asc_pkg::IMASK_IDX);
  endfunction

  always_comb
  begin
    s_next = s_reg;
    dbuf_wr = 1'b0;
    dbuf_rd = 1'b0;
    kbuf_wr = 1'b0;
    kbuf_rd = 1'b0;
    dbuf_load = 1'b0;
    buf_clr = 1'b0;
    core_start = 1'b0;
    core_abort = 1'b0;
    ev_done = 1'b0;
    ev_err = 1'b0;
    // Chaining XORs the previous ciphertext in front of encryption and
    // behind decryption; the first block after sleep chains with zero.
    result = core_out;
    if (s_reg.ctrl[asc_pkg::MODE_BIT] && s_reg.ctrl[asc_pkg::DIR_BIT])
      result = core_out ^ s_reg.iv;
    core_din = dbuf_blk;
    if (s_reg.wbyte[asc_pkg::MODE_BIT] && !s_reg.wbyte[asc_pkg::DIR_BIT])
      core_din = dbuf_blk ^ s_reg.iv;
    s_next.slp_meta = TRX_SLEEP;
    s_next.slp = s_reg.slp_meta;

    // Write channel: address and data are taken in either order.
    if (AWVALID && !s_reg.aw_rdy_n)
    begin
      s_next.aw_rdy_n = 1'b1;
      s_next.awaddr = AWADDR;
    end
    if (WVALID && !s_reg.w_rdy_n)
    begin
      s_next.w_rdy_n = 1'b1;
      s_next.wbyte = WDATA[7:0];
      s_next.wen = WSTRB[0];
    end
    wr_go = s_reg.aw_rdy_n && s_reg.w_rdy_n && !s_reg.bvalid;
    wr_ok = wr_go && s_reg.wen && !s_reg.slp;
    start_req = wr_ok && hit(s_reg.awaddr, asc_pkg::CTRL_IDX) &&
                s_reg.wbyte[asc_pkg::REQ_BIT] && !busy;
    if (wr_go)
    begin
      s_next.bvalid = 1'b1;
      s_next.bresp = mapped(s_reg.awaddr) ? asc_pkg::RESP_OKAY :
                     asc_pkg::RESP_SLVERR;
    end
    if (s_reg.bvalid && BREADY)
    begin
      s_next.bvalid = 1'b0;
      s_next.aw_rdy_n = 1'b0;
      s_next.w_rdy_n = 1'b0;
    end

    if (wr_ok)
    begin
      if (hit(s_reg.awaddr, asc_pkg::CTRL_IDX))
      begin
        s_next.ctrl = s_reg.wbyte & asc_pkg::CTRL_WMASK;
        if (busy)
        begin
          core_abort = 1'b1;
          s_next.ctrl[asc_pkg::REQ_BIT] = 1'b0;
          s_next.err = 1'b1;
          ev_err = 1'b1;
        end
      end
      if (hit(s_reg.awaddr, asc_pkg::DATA_IDX))
        dbuf_wr = 1'b1;
      if (hit(s_reg.awaddr, asc_pkg::KEY_IDX))
      begin
        kbuf_wr = 1'b1;
        s_next.show_last = 1'b0;
      end
      if (hit(s_reg.awaddr, asc_pkg::ISTAT_IDX))
        s_next.istat = s_reg.istat & ~s_reg.wbyte;
      if (hit(s_reg.awaddr, asc_pkg::IMASK_IDX))
        s_next.imask = s_reg.wbyte & asc_pkg::STAT_MASK;
      // Writes to the status register fall through with no effect.
    end

    if (start_req)
    begin
      s_next.err = 1'b0;
      s_next.done = 1'b0;
      if (!dbuf_cmp || !kbuf_cmp)
      begin
        s_next.err = 1'b1;
        s_next.ctrl[asc_pkg::REQ_BIT] = 1'b0;
        ev_err = 1'b1;
      end
      else
      begin
        core_start = 1'b1;
        s_next.in_blk = dbuf_blk;
      end
    end

    // Read channel: the answer stands from the same edge that takes the address.
    rd_go = ARVALID && !s_reg.ar_rdy_n;
    if (rd_go)
    begin
      s_next.ar_rdy_n = 1'b1;
      s_next.rvalid = 1'b1;
      s_next.rresp = mapped(ARADDR) ? asc_pkg::RESP_OKAY :
                     asc_pkg::RESP_SLVERR;
      s_next.rdata = asc_pkg::REG_RST;
      if (hit(ARADDR, asc_pkg::CTRL_IDX))
      begin
        s_next.rdata = s_reg.ctrl;
        if (busy && !s_reg.slp)
        begin
          core_abort = 1'b1;
          s_next.ctrl[asc_pkg::REQ_BIT] = 1'b0;
          s_next.err = 1'b1;
          ev_err = 1'b1;
        end
      end
      if (hit(ARADDR, asc_pkg::STAT_IDX))
        s_next.rdata = {s_reg.err, 6'h00, s_reg.done};
      if (hit(ARADDR, asc_pkg::DATA_IDX))
      begin
        s_next.rdata = dbuf_rdata;
        dbuf_rd = !s_reg.slp;
      end
      if (hit(ARADDR, asc_pkg::KEY_IDX))
      begin
        // The written key stays intact for the next run.
        s_next.rdata = s_reg.show_last ? core_lk[~kptr] : kbuf_rdata;
        kbuf_rd = !s_reg.slp;
      end
      if (hit(ARADDR, asc_pkg::ISTAT_IDX))
        s_next.rdata = s_reg.istat;
      if (hit(ARADDR, asc_pkg::IMASK_IDX))
        s_next.rdata = s_reg.imask;
    end
    if (s_reg.rvalid && RREADY)
    begin
      s_next.rvalid = 1'b0;
      s_next.ar_rdy_n = 1'b0;
    end

    if (core_done)
    begin
      dbuf_load = 1'b1;
      s_next.iv = s_reg.ctrl[asc_pkg::DIR_BIT] ? s_reg.in_blk : result;
      s_next.done = 1'b1;
      s_next.ctrl[asc_pkg::REQ_BIT] = 1'b0;
      s_next.show_last = 1'b1;
      ev_done = 1'b1;
    end

    // Set wins over a same-cycle clear by software.
    s_next.istat[asc_pkg::DONE_BIT] = s_next.istat[asc_pkg::DONE_BIT] |
                                      ev_done;
    s_next.istat[asc_pkg::ERR_BIT] = s_next.istat[asc_pkg::ERR_BIT] |
                                     ev_err;

    if (s_reg.slp)
    begin
      s_next.ctrl = asc_pkg::REG_RST;
      s_next.err = 1'b0;
      s_next.done = 1'b0;
      s_next.show_last = 1'b0;
      s_next.iv = '0;
      core_abort = 1'b1;
      buf_clr = 1'b1;
    end
    s_next.irq = s_next.ctrl[asc_pkg::IE_BIT] &&
                 |(s_next.istat & s_next.imask);
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign AWREADY = !s_reg.aw_rdy_n;
  assign WREADY = !s_reg.w_rdy_n;
  assign BVALID = s_reg.bvalid;
  assign BRESP = s_reg.bresp;
  assign ARREADY = !s_reg.ar_rdy_n;
  assign RVALID = s_reg.rvalid;
  assign RRESP = s_reg.rresp;
  assign RDATA = {24'h00_0000, s_reg.rdata};
  assign IRQ = s_reg.irq;

  asc_bytebuf u_data_buf (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .clr(buf_clr),
    .wr(dbuf_wr),
    .rd(dbuf_rd),
    .wdata(s_reg.wbyte),
    .load(dbuf_load),
    .load_val(result),
    .rdata(dbuf_rdata),
    .ptr(),
    .blk(dbuf_blk),
    .complete(dbuf_cmp)
  );

  asc_bytebuf u_key_buf (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .clr(buf_clr),
    .wr(kbuf_wr),
    .rd(kbuf_rd),
    .wdata(s_reg.wbyte),
    .load(1'b0),
    .load_val(128'h0),
    .rdata(kbuf_rdata),
    .ptr(kptr),
    .blk(kbuf_blk),
    .complete(kbuf_cmp)
  );

  asc_core u_core (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .start(core_start),
    .abort(core_abort),
    .dec(s_reg.wbyte[asc_pkg::DIR_BIT]),
    .key(kbuf_blk),
    .din(core_din),
    .busy(busy),
    .done(core_done),
    .dout(core_out),
    .last_key(core_lk)
  );

  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence ctrl_touch;
    busy && !s_reg.slp && ((wr_ok && hit(s_reg.awaddr, asc_pkg::CTRL_IDX)) ||
    (rd_go && hit(ARADDR, asc_pkg::CTRL_IDX)));
  endsequence

  chk_start_run: assert property (start_req && dbuf_cmp && kbuf_cmp
    |=> busy ##1 busy)
    else $error("Request with loaded buffers did not start the core.");
  chk_abort_touch: assert property (ctrl_touch |=> !busy && s_reg.err)
    else $error("Control access during a run did not abort with error.");
  chk_start_partial: assert property (start_req && !(dbuf_cmp && kbuf_cmp)
    |=> !busy && s_reg.err && s_reg.istat[asc_pkg::ERR_BIT])
    else $error("Start with a partial buffer gave no error.");
  chk_irq_gate: assert property (!s_reg.ctrl[asc_pkg::IE_BIT] |-> !IRQ)
    else $error("Interrupt raised while its enable is clear.");
  chk_sleep_clear: assert property (s_reg.slp
    |=> s_reg.ctrl == asc_pkg::REG_RST && !s_reg.err && !s_reg.done)
    else $error("Sleep did not clear control and status.");
  chk_done_irq: assert property (core_done && !s_reg.slp &&
    s_reg.ctrl[asc_pkg::IE_BIT] && s_reg.imask[asc_pkg::DONE_BIT]
    |=> s_reg.done && IRQ)
    else $error("Completion did not set done and raise the interrupt.");
  chk_status_ro: assert property (wr_ok &&
    hit(s_reg.awaddr, asc_pkg::STAT_IDX) && !core_done && !busy
    |=> $stable({s_reg.err, s_reg.done}))
    else $error("A status write changed the status flags.");
  chk_key_last: assert property (rd_go && hit(ARADDR, asc_pkg::KEY_IDX) &&
    s_reg.show_last |=> RDATA[7:0] == $past(core_lk[~kptr]))
    else $error("Key read did not return the last round key.");
endmodule

// File: tb/aes_security_module_control_tb.sv
// Self-checking bench for the AES security control block.
`timescale 1ns/1ps
module aes_security_module_control_tb;
  localparam logic [11:0] a_ctrl = {asc_pkg::CTRL_IDX, 2'b00};
  localparam logic [11:0] a_stat = {asc_pkg::STAT_IDX, 2'b00};
  localparam logic [11:0] a_data = {asc_pkg::DATA_IDX, 2'b00};
  localparam logic [11:0] a_key = {asc_pkg::KEY_IDX, 2'b00};
  localparam logic [11:0] a_ist = {asc_pkg::ISTAT_IDX, 2'b00};
  localparam logic [11:0] a_msk = {asc_pkg::IMASK_IDX, 2'b00};
  // Known-answer vector of the AES-128 standard and its final round key.
  localparam logic [127:0] kat_key = 128'h0001_0203_0405_0607_0809_0A0B_0C0D_0E0F;
  localparam logic [127:0] kat_pt = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF;
  localparam logic [127:0] kat_ct = 128'h69C4_E0D8_6A7B_0430_D8CD_B780_70B4_C55A;
  localparam logic [127:0] kat_rk = 128'h1311_1D7F_E394_4A17_F307_A78B_4D2B_30C5;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [11:0] AWADDR = 12'h000;
  logic AWVALID = 1'b0;
  logic AWREADY;
  logic [31:0] WDATA = 32'h0000_0000;
  logic [3:0] WSTRB = 4'hF;
  logic WVALID = 1'b0;
  logic WREADY;
  logic [1:0] BRESP;
  logic BVALID;
  logic BREADY = 1'b0;
  logic [11:0] ARADDR = 12'h000;
  logic ARVALID = 1'b0;
  logic ARREADY;
  logic [31:0] RDATA;
  logic [1:0] RRESP;
  logic RVALID;
  logic RREADY = 1'b0;
  logic TRX_SLEEP = 1'b0;
  logic IRQ;
  int fail_count = 0;
  int num_checks = 0;
  logic [33:0] exq[$];
  logic [33:0] mkq[$];
  logic [33:0] e;
  logic [33:0] m;
  logic [31:0] seed = 32'h0000_0054;
  logic [127:0] p, k, c, k2, t;
  logic [7:0] q;
  logic [1:0] bexp = 2'h0;

  asc_top i_asc_top (.REF_CLK(REF_CLK), .RST_N(RST_N), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .TRX_SLEEP(TRX_SLEEP), .IRQ(IRQ));

  always #50 REF_CLK = ~REF_CLK;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string n, input logic [33:0] ev,
      input logic [33:0] g);
    num_checks++;
    if (g !== ev)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, ev, g);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Ready lines drop once address or data is taken and rise again only after
  // the response, so back-to-back calls never assign the same signal twice in one time step.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    AWADDR <= a;
    WDATA <= {24'h00_0000, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do
    begin
      @(posedge REF_CLK);
      if (AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WREADY === 1'b1) WVALID <= 1'b0;
    end
    while (BVALID !== 1'b1);
    chk("bresp", {32'h0000_0000, bexp}, {32'h0000_0000, BRESP});
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] ev,
      input logic [33:0] mk, output logic [7:0] r);
    exq.push_back(ev & mk);
    mkq.push_back(mk);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do
    begin
      @(posedge REF_CLK);
      if (ARREADY === 1'b1) ARVALID <= 1'b0;
    end
    while (RVALID !== 1'b1);
    r = RDATA[7:0];
  endtask

  task automatic rx(input logic [11:0] a, input logic [33:0] ev);
    rd(a, ev, '1, q);
  endtask

  task automatic ld(input logic [11:0] a, input logic [127:0] v);
    for (int i = 0; i < 16; i++)
      wr(a, v[127 - 8 * i -: 8]);
  endtask

  task automatic rb(input logic [11:0] a, input logic [127:0] v,
      input logic [7:0] mk, output logic [127:0] g);
    logic [7:0] b;
    for (int i = 0; i < 16; i++)
    begin
      rd(a, {26'h000_0000, v[127 - 8 * i -: 8]}, {2'h3, 24'h00_0000, mk}, b);
      g[127 - 8 * i -: 8] = b;
    end
  endtask

  task automatic wi();
    int n;
    n = 0;
    while (IRQ !== 1'b1 && n < 40)
    begin
      @(posedge REF_CLK);
      n++;
    end
  endtask

  always @(posedge REF_CLK)
  begin
    if (RVALID === 1'b1 && RREADY === 1'b1 && exq.size() > 0)
    begin
      e = exq.pop_front();
      m = mkq.pop_front();
      chk("read", e, {RRESP, RDATA} & m);
    end
  end

  initial
  begin
    repeat (20000) @(posedge REF_CLK);
    fail_count++;
    end_sim();
  end

  initial
  begin
    p = {xs(), xs(), xs(), xs()};
    k = {xs(), xs(), xs(), xs()};
    repeat (3) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    rx(a_ctrl, 34'h0_0000_0000);
    rx(a_stat, 34'h0_0000_0000);
    rx(12'h008, 34'h2_0000_0000);
    bexp = 2'h2;
    wr(12'h008, 8'hFF);
    bexp = 2'h0;
    wr(a_stat, 8'hFF);
    rx(a_stat, 34'h0_0000_0000);
    wr(a_ctrl, 8'h2C);
    rx(a_ctrl, 34'h0_0000_002C);
    wr(a_msk, 8'h81);
    WSTRB <= 4'h0;
    wr(a_msk, 8'h00);
    WSTRB <= 4'hF;
    rx(a_msk, 34'h0_0000_0081);
    wr(a_ctrl, 8'h84);
    wi();
    chk("irq", 34'h0_0000_0001, {33'h0_0000_0000, IRQ});
    rx(a_stat, 34'h0_0000_0080);
    rx(a_ist, 34'h0_0000_0080);
    wr(a_ist, 8'h80);
    chk("irq", 34'h0_0000_0000, {33'h0_0000_0000, IRQ});
    ld(a_key, k);
    ld(a_data, p);
    wr(a_ctrl, 8'h84);
    wi();
    chk("irq", 34'h0_0000_0001, {33'h0_0000_0000, IRQ});
    rx(a_stat, 34'h0_0000_0001);
    rb(a_data, p, 8'h00, c);
    rb(a_key, k, 8'h00, k2);
    wr(a_ist, 8'h81);
    // Decrypting the ciphertext with the last round key must give the
    // plaintext back, which checks the cipher without a reference model.
    ld(a_key, k2);
    ld(a_data, c);
    wr(a_ctrl, 8'h8C);
    wi();
    rb(a_data, p, 8'hFF, t);
    wr(a_ist, 8'h81);
    wr(a_ctrl, 8'h24);
    TRX_SLEEP <= 1'b1;
    repeat (5) @(posedge REF_CLK);
    TRX_SLEEP <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    rx(a_ctrl, 34'h0_0000_0000);
    rx(a_stat, 34'h0_0000_0000);
    // Sleep resets the chaining value to zero, so a first chained block
    // must equal the code book result.
    ld(a_key, k);
    ld(a_data, p);
    wr(a_ctrl, 8'hA4);
    wi();
    rb(a_data, c, 8'hFF, t);
    // The chaining value is now the last ciphertext, so a chained
    // decryption of that same block gives the plaintext XOR the block.
    wr(a_ist, 8'h81);
    ld(a_key, k2);
    ld(a_data, c);
    wr(a_ctrl, 8'hAC);
    wi();
    rb(a_data, p ^ c, 8'hFF, t);
    wr(a_ist, 8'h81);
    ld(a_data, p);
    wr(a_ctrl, 8'h84);
    rd(a_ctrl, 34'h0_0000_0004, 34'h3_0000_002C, q);
    wi();
    chk("irq", 34'h0_0000_0001, {33'h0_0000_0000, IRQ});
    rx(a_stat, 34'h0_0000_0080);
    wr(a_ist, 8'h81);
    wr(a_ctrl, 8'h80);
    repeat (20) @(posedge REF_CLK);
    chk("irq", 34'h0_0000_0000, {33'h0_0000_0000, IRQ});
    // The last result was never read out, so a new start must fail.
    wr(a_ist, 8'h81);
    wr(a_ctrl, 8'h84);
    wi();
    rx(a_stat, 34'h0_0000_0080);
    wr(a_ist, 8'h81);
    ld(a_key, kat_key);
    ld(a_data, kat_pt);
    wr(a_ctrl, 8'h84);
    wi();
    rb(a_data, kat_ct, 8'hFF, t);
    rb(a_key, kat_rk, 8'hFF, t);
    // Reading the key must not disturb the key used by the next run.
    wr(a_ist, 8'h81);
    ld(a_data, kat_pt);
    wr(a_ctrl, 8'h84);
    wi();
    rb(a_data, kat_ct, 8'hFF, t);
    end_sim();
  end
endmodule
